// ===== common/cbf_consts.svh
`ifndef CBF_CONSTS_SVH
`define CBF_CONSTS_SVH

// Register byte offsets
`define CBF_REG_CFG 8'h00
`define CBF_REG_GAP 8'h04
`define CBF_REG_BGT 8'h08
`define CBF_REG_BWT 8'h0c
`define CBF_REG_STAT 8'h10
`define CBF_REG_TC 8'h14

// Reset values
`define CBF_CARD_RX_PAYLOAD_MAX_RST 8'h20
`define CBF_WTX_MULT_RST 8'h01
`define CBF_GAP_RST 16'h002c
`define CBF_BGT_RST 16'h0016
`define CBF_BWT_RST 16'h0400

// Field and frame constants
`define CBF_TC_VAL 8'h00
`define CBF_NAD_DEF 8'h00
`define CBF_INF_MAX 8'hfe
`define CBF_INF_ONE 8'h01
`define CBF_INF_NONE 8'h00
`define CBF_PCB_R_EDC 8'h81
`define CBF_PCB_R_OTHER 8'h82
`define CBF_PCB_S_WTX_REQ 8'hc3
`define CBF_PCB_S_WTX_RSP 8'he3
`define CBF_PCB_S_RSP_BIT 8'h20
`define CBF_S_TYPE_IFS 5'h01
`define CBF_S_TYPE_WTX 5'h03
`define CBF_WTX_LEAD 16'h0002

`endif

// ===== common/cbf_pkg.sv
`default_nettype none

package cbf_pkg;

    // One character with its strobe
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } cbf_char_s;

    // Reply header handed over by the application
    typedef struct packed {
        logic [7:0] block_control_byte;
        logic [7:0] len;
    } cbf_reply_s;

    // Receive parser, Gray codes along the frame
    typedef enum logic [2:0] {
        RX_NAD = 3'h0,
        RX_PCB = 3'h1,
        RX_LEN = 3'h3,
        RX_INF = 3'h2,
        RX_LRC = 3'h6
    } cbf_rx_e;

    // Transmit sequencer, Gray codes along the frame
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_NAD = 3'h1,
        TX_PCB = 3'h3,
        TX_LEN = 3'h2,
        TX_INF = 3'h6,
        TX_LRC = 3'h7
    } cbf_tx_e;

    // Source of the block being sent
    typedef enum logic [1:0] {
        SRC_AUTO = 2'h0,
        SRC_WTX = 2'h1,
        SRC_APP = 2'h3
    } cbf_src_e;

endpackage : cbf_pkg

`default_nettype wire

// ===== rtl/cbf_etu_timer.sv
`default_nettype none

module cbf_etu_timer
#(
    parameter int unsigned TW = 16
)
(
    input wire logic clk_i,        // Clock
    input wire logic nrst_i,       // Sync reset, active low
    input wire logic restart_i,    // Restart from zero
    input wire logic tick_i,       // One etu elapsed
    output logic [TW-1:0] count_o  // Etus since restart
);

    logic [TW-1:0] cnt_q;

    // Saturating count so a long idle never wraps into a short delay
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            cnt_q <= '0;
        else if (restart_i)
            cnt_q <= '0;
        else if (tick_i && (cnt_q != '1))
            cnt_q <= cnt_q + 1'b1;
    end

    assign count_o = cnt_q;

endmodule : cbf_etu_timer

`default_nettype wire

// ===== rtl/cbf_framer.sv
// Functional notes
// RQ1: Character gap kept below gap limit
// RQ2: Reply starts after guard, before timeout
// RQ3: Turnaround window dropped after wait extension
// RQ4: Next command accepted right after reply
// RQ5: Extra time requested with extension block
// RQ6: Check type character reads zero
// RQ7: Own blocks sent with node address zero
// RQ8: Nonzero node address block silently dropped
// RQ9: Control byte identifies block type
// RQ10: Information, receive-ready, supervisory blocks handled
// RQ11: Length byte equals payload byte count
// RQ12: Information blocks always carry payload
// RQ13: Receive-ready blocks have zero length
// RQ14: Size and extension blocks carry one byte
// RQ15: Other supervisory blocks carry no payload
// RQ16: Receivable payload size defaults to 32
// RQ17: Every block ends with xor check
// RQ18: Bad check answered with error-one block
// RQ19: Check byte xors prologue and payload
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "cbf_consts.svh"
`default_nettype none

module cbf_framer
    import cbf_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 254,
    parameter int unsigned TW = 16
)
(
    input wire logic clk_i,              // Clock, 125 MHz
    input wire logic nrst_i,             // Sync reset, active low
    input wire logic etu_tick_i,         // One pulse per etu
    input wire cbf_char_s ch_rx_i,       // Received character
    output cbf_char_s ch_tx_o,           // Character to send
    input wire logic ch_tx_ready_i,      // Character layer takes it
    output cbf_char_s app_rx_o,          // Payload byte to application
    output logic app_blk_done_o,         // Good block for application
    output logic [7:0] app_blk_pcb_o,    // Its control byte
    output logic [7:0] app_blk_len_o,    // Its length byte
    input wire logic app_wr_i,           // Payload buffer write
    input wire logic [7:0] app_wr_idx_i, // Payload buffer index
    input wire logic [7:0] app_wr_data_i,// Payload buffer data
    input wire logic app_send_i,         // Reply is ready
    input wire cbf_reply_s app_reply_i,  // Reply header
    output logic app_busy_o,             // Reply still pending
    input wire logic [7:0] reg_addr_i,   // Register byte address
    input wire logic [31:0] reg_wdata_i, // Register write data
    input wire logic reg_we_i,           // Write strobe
    input wire logic reg_re_i,           // Read strobe
    output logic [31:0] reg_rdata_o      // Read data, next cycle
);

    // RQ12 RQ13 RQ14 RQ15: forced length per type
    function automatic logic [7:0] fix_len(input logic [7:0] block_control_byte,
                                          input logic [7:0] len);
        logic [4:0] st;
        st = block_control_byte[4:0];
        if (!block_control_byte[7])
            fix_len = (len == 8'h00) ? `CBF_INF_ONE :
                      (len > `CBF_INF_MAX) ? `CBF_INF_MAX : len;
        else if (!block_control_byte[6])
            fix_len = `CBF_INF_NONE;
        else if (st == `CBF_S_TYPE_IFS || st == `CBF_S_TYPE_WTX)
            fix_len = `CBF_INF_ONE;
        else
            fix_len = `CBF_INF_NONE;
    endfunction : fix_len

    logic [7:0] card_rx_payload_max_q, wtx_mult_q, discard_q;
    logic [TW-1:0] gap_q, bgt_q, bwt_q, turn_cnt, gap_cnt;
    cbf_rx_e rx_st_q;
    logic [7:0] rx_nad_q, rx_pcb_q, rx_len_q, rx_inf0_q, rx_lrc_q;
    logic [7:0] rx_cnt_q;
    cbf_tx_e tx_st_q;
    cbf_src_e tx_src_q;
    logic [7:0] tx_byte_q, tx_pcb_q, tx_len_q, tx_lrc_q, tx_idx_q;
    logic [7:0] tx_inf1_q;
    logic [7:0] buf_q [BUF_DEPTH];
    logic auto_pend_q, reply_wait_q, wtx_sent_q, wtx_active_q;
    logic [7:0] auto_pcb_q, auto_len_q, auto_inf_q;
    logic app_pend_q, blk_done_q;
    cbf_reply_s app_rep_q;
    cbf_char_s app_rx_q;

    logic rx_end, lrc_ok, addr_ok, len_ok, s_req;
    logic hs, tx_go, tx_start, wtx_need, app_go, window_ok;
    logic [7:0] lrc_n, inf_byte;

    // Leading edge of last received character restarts turnaround
    cbf_etu_timer #(.TW(TW)) u_turn (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .restart_i(ch_rx_i.valid),
        .tick_i(etu_tick_i),
        .count_o(turn_cnt)
    );

    // RQ1: gap timer restarts per character
    cbf_etu_timer #(.TW(TW)) u_gap (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .restart_i(hs || tx_start),
        .tick_i(etu_tick_i),
        .count_o(gap_cnt)
    );

    // Receive parser; a stalled frame is dropped after the gap limit
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            rx_st_q <= RX_NAD;
            rx_nad_q <= 8'h00;
            rx_pcb_q <= 8'h00;
            rx_len_q <= 8'h00;
            rx_inf0_q <= 8'h00;
            rx_lrc_q <= 8'h00;
            rx_cnt_q <= 8'h00;
        end
        else if (ch_rx_i.valid)
        begin
            // RQ19: xor accumulate check
            rx_lrc_q <= (rx_st_q == RX_NAD) ? ch_rx_i.data
                                            : rx_lrc_q ^ ch_rx_i.data;
            unique case (rx_st_q)
                RX_NAD:
                begin
                    rx_nad_q <= ch_rx_i.data;
                    rx_st_q <= RX_PCB;
                end
                RX_PCB:
                begin
                    rx_pcb_q <= ch_rx_i.data;
                    rx_st_q <= RX_LEN;
                end
                RX_LEN:
                begin
                    rx_len_q <= ch_rx_i.data;
                    rx_cnt_q <= 8'h00;
                    rx_st_q <= (ch_rx_i.data == 8'h00) ? RX_LRC : RX_INF;
                end
                RX_INF:
                begin
                    if (rx_cnt_q == 8'h00)
                        rx_inf0_q <= ch_rx_i.data;
                    rx_cnt_q <= rx_cnt_q + 8'h01;
                    if (rx_cnt_q == rx_len_q - 8'h01)
                        rx_st_q <= RX_LRC;
                end
                RX_LRC:
                    rx_st_q <= RX_NAD;
                default:
                    rx_st_q <= RX_NAD;
            endcase
        end
        else if (rx_st_q != RX_NAD && turn_cnt > gap_q)
            rx_st_q <= RX_NAD;
    end

    // Block classification at the check byte
    assign rx_end = ch_rx_i.valid && (rx_st_q == RX_LRC);
    assign lrc_ok = ((rx_lrc_q ^ ch_rx_i.data) == 8'h00);
    // RQ8: both address subfields must be zero
    assign addr_ok = (rx_nad_q == `CBF_NAD_DEF);
    // RQ16: payload above the receivable size is an error
    assign len_ok = (rx_len_q == fix_len(rx_pcb_q, rx_len_q))
                    && !(!rx_pcb_q[7] && rx_len_q > card_rx_payload_max_q);
    assign s_req = (rx_pcb_q[7:5] == 3'b110)
                   && (rx_pcb_q[4:0] != `CBF_S_TYPE_WTX);

    // Payload bytes pass to the application as they arrive
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            app_rx_q <= '0;
        else
        begin
            app_rx_q.valid <= ch_rx_i.valid && (rx_st_q == RX_INF);
            app_rx_q.data <= ch_rx_i.data;
        end
    end

    // Reply bookkeeping; a new block wins over a same-cycle start
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            auto_pend_q <= 1'b0;
            auto_pcb_q <= 8'h00;
            auto_len_q <= 8'h00;
            auto_inf_q <= 8'h00;
            reply_wait_q <= 1'b0;
            wtx_sent_q <= 1'b0;
            wtx_active_q <= 1'b0;
            discard_q <= 8'h00;
            blk_done_q <= 1'b0;
        end
        else
        begin
            blk_done_q <= 1'b0;
            if (tx_start)
            begin
                unique case (auto_pend_q ? SRC_AUTO :
                             wtx_need ? SRC_WTX : SRC_APP)
                    SRC_AUTO: auto_pend_q <= 1'b0;
                    SRC_WTX: wtx_sent_q <= 1'b1;
                    SRC_APP:
                    begin
                        reply_wait_q <= 1'b0;
                        wtx_active_q <= 1'b0;
                        wtx_sent_q <= 1'b0;
                    end
                endcase
            end
            if (rx_end && !addr_ok)
                discard_q <= discard_q + 8'h01;
            else if (rx_end)
            begin
                if (!lrc_ok)
                begin
                    // RQ18: error-one receive-ready reply
                    auto_pend_q <= 1'b1;
                    auto_pcb_q <= `CBF_PCB_R_EDC;
                    auto_len_q <= `CBF_INF_NONE;
                end
                else if (!len_ok)
                begin
                    auto_pend_q <= 1'b1;
                    auto_pcb_q <= `CBF_PCB_R_OTHER;
                    auto_len_q <= `CBF_INF_NONE;
                end
                else if (s_req)
                begin
                    // RQ10: supervisory requests answered here
                    auto_pend_q <= 1'b1;
                    auto_pcb_q <= rx_pcb_q | `CBF_PCB_S_RSP_BIT;
                    auto_len_q <= rx_len_q;
                    auto_inf_q <= rx_inf0_q;
                end
                else if (rx_pcb_q == `CBF_PCB_S_WTX_RSP)
                begin
                    // RQ3: window lifted once extension exchanged
                    wtx_active_q <= wtx_sent_q;
                    wtx_sent_q <= 1'b0;
                end
                else
                begin
                    // RQ4: command taken whenever the line is idle
                    reply_wait_q <= 1'b1;
                    blk_done_q <= 1'b1;
                end
            end
        end
    end

    // Application reply latch; a new request wins over the clear
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            app_pend_q <= 1'b0;
            app_rep_q <= '0;
        end
        else if (app_send_i)
        begin
            app_pend_q <= 1'b1;
            app_rep_q <= app_reply_i;
        end
        else if (tx_start && !auto_pend_q && !wtx_need)
            app_pend_q <= 1'b0;
    end

    // Payload store; written on every app_wr_i with index below BUF_DEPTH, even while a reply is pending
    always_ff @(posedge clk_i)
    begin
        if (app_wr_i && app_wr_idx_i < BUF_DEPTH[7:0])
            buf_q[app_wr_idx_i] <= app_wr_data_i;
    end

    // RQ2: start only inside the turnaround window
    assign window_ok = wtx_active_q || (turn_cnt > bgt_q);
    // RQ5: ask for more time just before the timeout
    assign wtx_need = reply_wait_q && !app_pend_q && !wtx_sent_q
                      && !wtx_active_q
                      && (turn_cnt >= bwt_q - `CBF_WTX_LEAD);
    assign app_go = reply_wait_q && app_pend_q;
    assign tx_go = (auto_pend_q || wtx_need || app_go) && window_ok
                   && (rx_st_q == RX_NAD);
    assign tx_start = (tx_st_q == TX_IDLE) && tx_go;
    assign hs = (tx_st_q != TX_IDLE) && ch_tx_ready_i;
    assign lrc_n = tx_lrc_q ^ tx_byte_q;
    assign inf_byte = (tx_src_q == SRC_APP) ? buf_q[tx_idx_q] : tx_inf1_q;

    // Transmit sequencer; whole payload is stored so gaps stay short
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            tx_st_q <= TX_IDLE;
            tx_src_q <= SRC_AUTO;
            tx_byte_q <= 8'h00;
            tx_pcb_q <= 8'h00;
            tx_len_q <= 8'h00;
            tx_lrc_q <= 8'h00;
            tx_idx_q <= 8'h00;
            tx_inf1_q <= 8'h00;
        end
        else if (tx_start)
        begin
            // RQ7: node address byte always zero
            tx_byte_q <= `CBF_NAD_DEF;
            tx_lrc_q <= 8'h00;
            tx_idx_q <= 8'h00;
            tx_st_q <= TX_NAD;
            // RQ9: control byte carries the block type
            if (auto_pend_q)
            begin
                tx_src_q <= SRC_AUTO;
                tx_pcb_q <= auto_pcb_q;
                tx_len_q <= fix_len(auto_pcb_q, auto_len_q);
                tx_inf1_q <= auto_inf_q;
            end
            else if (wtx_need)
            begin
                tx_src_q <= SRC_WTX;
                tx_pcb_q <= `CBF_PCB_S_WTX_REQ;
                tx_len_q <= `CBF_INF_ONE;
                tx_inf1_q <= wtx_mult_q;
            end
            else
            begin
                // RQ11: length forced to the type's payload
                tx_src_q <= SRC_APP;
                tx_pcb_q <= app_rep_q.block_control_byte;
                tx_len_q <= fix_len(app_rep_q.block_control_byte, app_rep_q.len);
            end
        end
        else if (hs)
        begin
            // RQ17: check byte follows the payload
            tx_lrc_q <= lrc_n;
            unique case (tx_st_q)
                TX_NAD:
                begin
                    tx_byte_q <= tx_pcb_q;
                    tx_st_q <= TX_PCB;
                end
                TX_PCB:
                begin
                    tx_byte_q <= tx_len_q;
                    tx_st_q <= TX_LEN;
                end
                TX_LEN:
                begin
                    tx_byte_q <= (tx_len_q == 8'h00) ? lrc_n : inf_byte;
                    tx_idx_q <= 8'h01;
                    tx_st_q <= (tx_len_q == 8'h00) ? TX_LRC : TX_INF;
                end
                TX_INF:
                begin
                    tx_byte_q <= (tx_idx_q == tx_len_q) ? lrc_n : inf_byte;
                    tx_idx_q <= tx_idx_q + 8'h01;
                    if (tx_idx_q == tx_len_q)
                        tx_st_q <= TX_LRC;
                end
                TX_LRC:
                    tx_st_q <= TX_IDLE;
                default:
                    tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // Register writes
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            // RQ16: default receivable payload size
            card_rx_payload_max_q <= `CBF_CARD_RX_PAYLOAD_MAX_RST;
            wtx_mult_q <= `CBF_WTX_MULT_RST;
            gap_q <= TW'(`CBF_GAP_RST);
            bgt_q <= TW'(`CBF_BGT_RST);
            bwt_q <= TW'(`CBF_BWT_RST);
        end
        else if (reg_we_i)
        begin
            unique case (reg_addr_i)
                `CBF_REG_CFG:
                begin
                    card_rx_payload_max_q <= reg_wdata_i[7:0];
                    wtx_mult_q <= reg_wdata_i[15:8];
                end
                `CBF_REG_GAP: gap_q <= reg_wdata_i[TW-1:0];
                `CBF_REG_BGT: bgt_q <= reg_wdata_i[TW-1:0];
                `CBF_REG_BWT: bwt_q <= reg_wdata_i[TW-1:0];
                default: ;
            endcase
        end
    end

    // Register reads, one cycle later; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_re_i)
        begin
            unique case (reg_addr_i)
                `CBF_REG_CFG: reg_rdata_o <= {16'h0000, wtx_mult_q, card_rx_payload_max_q};
                `CBF_REG_GAP: reg_rdata_o <= 32'(gap_q);
                `CBF_REG_BGT: reg_rdata_o <= 32'(bgt_q);
                `CBF_REG_BWT: reg_rdata_o <= 32'(bwt_q);
                `CBF_REG_STAT: reg_rdata_o <= {16'h0000, discard_q,
                    app_pend_q, wtx_active_q, rx_st_q, tx_st_q};
                // RQ6: check type character, check by xor only
                `CBF_REG_TC: reg_rdata_o <= {24'h000000, `CBF_TC_VAL};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_o <= 32'h0000_0000;
    end

    assign ch_tx_o.valid = (tx_st_q != TX_IDLE);
    assign ch_tx_o.data = tx_byte_q;
    assign app_rx_o = app_rx_q;
    assign app_blk_done_o = blk_done_q;
    assign app_blk_pcb_o = rx_pcb_q;
    assign app_blk_len_o = rx_len_q;
    assign app_busy_o = app_pend_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_len_char;
        hs && tx_st_q == TX_LEN;
    endsequence

    sequence s_fresh_start;
        tx_start && !wtx_active_q && !wtx_sent_q;
    endsequence

    AST_GAP_LIMIT: assert property ( // RQ1
        ch_tx_o.valid |-> gap_cnt < gap_q)
        else $error("Character gap reached the limit");
    AST_GUARD: assert property ( // RQ2
        s_fresh_start |-> turn_cnt > bgt_q)
        else $error("Reply started inside guard time");
    AST_TIMEOUT: assert property ( // RQ2
        s_fresh_start |-> turn_cnt < bwt_q)
        else $error("Reply started after timeout");
    AST_NAD_ZERO: assert property ( // RQ7
        tx_start |=> ch_tx_o.valid && ch_tx_o.data == 8'h00)
        else $error("Node address byte not zero");
    AST_R_LEN: assert property ( // RQ13
        (s_len_char and (tx_pcb_q[7:6] == 2'b10)) |-> ch_tx_o.data == 8'h00)
        else $error("Receive-ready block with payload");
    AST_S_LEN: assert property ( // RQ14
        (s_len_char and (tx_pcb_q[7:6] == 2'b11))
        |-> ch_tx_o.data == fix_len(tx_pcb_q, 8'h00))
        else $error("Supervisory length wrong");
    AST_BAD_CHECK: assert property ( // RQ18
        rx_end && addr_ok && !lrc_ok
        |=> auto_pend_q && auto_pcb_q == 8'h81 && auto_len_q == 8'h00)
        else $error("Bad check not answered");
    AST_DISCARD: assert property ( // RQ8
        rx_end && !addr_ok |=> !blk_done_q && $stable(auto_pend_q))
        else $error("Foreign address block not dropped");
    AST_WTX: assert property ( // RQ5
        tx_start && wtx_need && !auto_pend_q
        |=> tx_pcb_q == 8'hc3 ##1 1'b1 [*1] ##[0:40] hs && tx_st_q == TX_LRC)
        else $error("Extension request not sent");
    AST_TC_ZERO: assert property ( // RQ6
        reg_re_i && reg_addr_i == 8'h14 |=> reg_rdata_o == 32'h0)
        else $error("Check type character not zero");

endmodule : cbf_framer

`default_nettype wire

// ===== verif/cbf_term_model.sv
`default_nettype none

module cbf_term_model
    import cbf_pkg::*;
(
    input wire logic clk_i,     // Clock
    input wire logic tick_i,    // Etu pulse
    input wire logic stall_i,   // Reader busy
    input wire cbf_char_s tx_i, // Card characters
    output logic ready_o,       // Takes card characters
    output cbf_char_s rx_o      // Terminal characters
);
    timeunit 1ns;
    timeprecision 1ps;
    int etu = 0;
    int last_rx = 0;
    int last_tx = 0;
    int first_gap = -1;
    int max_gap = 0;
    logic [7:0] got[$];

    // A real reader may stall any character
    assign ready_o = ~stall_i;

    // Etu count and gaps seen on the card's characters
    always @(posedge clk_i)
    begin
        etu = etu + int'(tick_i);
        if (tx_i.valid && ready_o)
        begin
            if (got.size() == 0)
                first_gap = etu - last_rx;
            else if (etu - last_tx > max_gap)
                max_gap = etu - last_tx;
            got.push_back(tx_i.data);
            last_tx = etu;
        end
    end

    // framed command with xor check, bad flips it
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [7:0] x;
        x = {7'h00, bad};
        foreach (b[i])
            x = x ^ b[i];
        b.push_back(x);
        foreach (b[i])
        begin
            @(posedge clk_i);
            rx_o <= '{valid: 1'b1, data: b[i]};
            last_rx = etu;
            @(posedge clk_i);
            rx_o <= '{valid: 1'b0, data: ~b[i]};
        end
    endtask : send

    initial rx_o = '0;
endmodule : cbf_term_model

`default_nettype wire

// ===== verif/test_card_block_protocol_framing.sv
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
 fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module test_card_block_protocol_framing;
    import cbf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] cbf_bytes_t[$];
    cbf_bytes_t nil;
    logic clk = 0, nrst_n = 0, tick = 0, stall = 0, ready, busy;
    logic app_wr = 0, app_send = 0, we = 0, re = 0, done;
    logic [7:0] idx = 0, wdat = 0, addr = 0, bpcb, blen, lastrx;
    logic [31:0] regw = 0, rdata, v, seed = 32'd83;
    cbf_char_s rx, tx, app_rx;
    cbf_reply_s reply = '0;
    int fails = 0, checks_done = 0, cyc = 0, nrx = 0;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h20};
    logic [31:0] rv[6] = '{32'h120, 32'h2c, 32'h16, 32'h400, 0, 0};
    logic [7:0] sp[3] = '{8'hc1, 8'hc0, 8'hc2};

    cbf_framer DUT (.clk_i(clk), .nrst_i(nrst_n), .etu_tick_i(tick),
        .ch_rx_i(rx), .ch_tx_o(tx), .ch_tx_ready_i(ready),
        .app_rx_o(app_rx), .app_blk_done_o(done), .app_blk_pcb_o(bpcb),
        .app_blk_len_o(blen), .app_wr_i(app_wr), .app_wr_idx_i(idx),
        .app_wr_data_i(wdat), .app_send_i(app_send),
        .app_reply_i(reply), .app_busy_o(busy), .reg_addr_i(addr),
        .reg_wdata_i(regw), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata));
    cbf_term_model P (.clk_i(clk), .tick_i(tick), .stall_i(stall),
        .tx_i(tx), .ready_o(ready), .rx_o(rx));

    // Clock, etu every 4 cycles, random reader stalls
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        tick <= (cyc % 4 == 3);
        stall <= rnd() % 3 == 0;
    end

    // Payload bytes handed to the application
    always @(posedge clk)
        if (app_rx.valid === 1'b1)
        begin
            nrx++;
            lastrx = app_rx.data;
        end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    // Expected card frame, address zero and xor check at the end
    function automatic cbf_bytes_t frame(input logic [7:0] p, l,
        input cbf_bytes_t d);
        cbf_bytes_t q;
        q = {8'h00, p, l, d};
        q.push_back(8'h00);
        foreach (d[i])
            q[q.size()-1] ^= d[i];
        q[q.size()-1] ^= p ^ l;
        return q;
    endfunction : frame

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        regw <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    // Two status bytes into the store, then the reply header
    task automatic app_reply(input logic [7:0] p);
        @(posedge clk);
        {app_wr, idx, wdat} <= {1'b1, 8'h00, 8'h90};
        @(posedge clk);
        {idx, wdat} <= {8'h01, 8'h00};
        @(posedge clk);
        app_wr <= 1'b0;
        app_send <= 1'b1;
        reply <= '{block_control_byte: p, len: 8'h02};
        @(posedge clk);
        app_send <= 1'b0;
        @(negedge clk);
        `CHK("busy", 1'b1, busy)
    endtask : app_reply

    task automatic expect_blk(input cbf_bytes_t e);
        for (int i = 0; i < 20000 && P.got.size() < e.size(); i++)
            @(negedge clk);
        repeat (80) @(negedge clk);
        `CHK("reply size", e.size(), P.got.size())
        foreach (e[i]) `CHK("reply byte", e[i], P.got[i])
        `CHK("turnaround", 1'b1, P.first_gap inside {[23:1023]})
        `CHK("char gap", 1'b1, P.max_gap < 44)
        P.got.delete();
        P.max_gap = 0;
    endtask : expect_blk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        #400us;
        fails++;
        test_done();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        nrst_n <= 1'b1;
        foreach (ra[i])
        begin
            rd(ra[i], v);
            `CHK("register", rv[i], v)
        end
        P.send({8'h00, 8'h00, 8'h01, rnd()}, 1'b1);
        expect_blk(frame(8'h81, 8'h00, nil));
        P.send({8'h00, sp[0], 8'h01, 8'hfe}, 0);
        expect_blk(frame(8'he1, 8'h01, {8'hfe}));
        for (int i = 1; i < 3; i++)
        begin
            P.send({8'h00, sp[i], 8'h00}, 0);
            expect_blk(frame(sp[i] | 8'h20, 8'h00, nil));
        end
        foreach (sp[i])
            P.send({i[1:0] + 8'h10 >> i[1], 8'h00, 8'h01, rnd()}, 0);
        repeat (900) @(negedge clk);
        `CHK("silent", 0, P.got.size())
        rd(8'h10, v);
        `CHK("dropped", 8'h03, v[15:8])
        for (int k = 0; k < 2; k++)
        begin
            P.send({8'h00, k ? 8'h40 : 8'h00, 8'h02, rnd(), rnd()}, 0);
            for (int i = 0; i < 20 && done !== 1'b1; i++)
                @(negedge clk);
            `CHK("block done", 1'b1, done)
            `CHK("block len", 8'h02, blen)
            app_reply(bpcb);
            expect_blk(frame(k ? 8'h40 : 8'h00, 2, {8'h90, 8'h00}));
            repeat (8) @(posedge clk);
        end
        wr(8'h0c, 32'h40);
        wr(8'h00, 32'h520);
        rd(8'h00, v);
        `CHK("config", 32'h520, v)
        P.send({8'h00, 8'h00, 8'h01, rnd()}, 0);
        expect_blk(frame(8'hc3, 8'h01, {8'h05}));
        P.send({8'h00, 8'he3, 8'h01, 8'h05}, 0);
        repeat (100) @(posedge clk);
        `CHK("payload", 8'h05, lastrx)
        `CHK("payload count", 11, nrx)
        app_reply(8'h00);
        expect_blk(frame(8'h00, 8'h02, {8'h90, 8'h00}));
        `CHK("busy", 1'b0, busy)
        test_done();
    end
endmodule : test_card_block_protocol_framing

`default_nettype wire
